/* File: common/core_platform_csr_regs.svh */
`ifndef CORE_PLATFORM_CSR_REGS_SVH
`define CORE_PLATFORM_CSR_REGS_SVH
// Behaviour
// - Reserved and unused bits read zero, ignore writes
// - Writable registers accept anything, hold legal values
// - Region control holds two bits per region
// - Side-effect bit marks non-idempotent region, resets zero
// - Caching bit permits caching, resets zero
// - Written pair side-effect+cacheable stored as side-effect only
// - Side-effect ignored for fetches and local targets
// - Caching ignored only for local instruction fetches
// - Sync trigger only in debug, else illegal
// - Trigger bits start data/instruction fence, read zero
// - First data-bus error latches address and locks
// - Locked capture gates bus errors, pin NMIs honoured
// - Capture read-only, resets zero, unlock by reset/write
// - Any unlock write clears lock, re-enables NMI
// - Unlock register always reads zero
// - Local partial write does read-modify-write, regenerates ECC
// - SoC writes carry byte enables, target does RMW
// - NMI cause codes distinguish store, load, pin
`define CSR_REGION_ACCESS 12'h7c0
`define CSR_SYNC_TRIGGER 12'h7c4
`define CSR_ERR_UNLOCK 12'hbc0
`define CSR_ERR_CAPTURE 12'hfc0
`define REGION_ACCESS_RESET 32'h0000_0000
`define CAPTURE_RESET 32'h0000_0000
`define SYNC_DATA_FENCE_BIT 1
`define SYNC_INSTR_FENCE_BIT 0
`define REGION_MSB 31
`define REGION_LSB 28
`define CAUSE_PIN 32'h0000_0000
`define CAUSE_STORE_ERR 32'hf000_0000
`define CAUSE_LOAD_ERR 32'hf000_0001
`define ECC_MASK0 32'h56aa_ad5b
`define ECC_MASK1 32'h9b33_366d
`define ECC_MASK2 32'he3c3_c78e
`define ECC_MASK3 32'h03fc_07f0
`define ECC_MASK4 32'h03ff_f800
`define ECC_MASK5 32'hfc00_0000
`endif

/* File: common/core_platform_csr_pkg.sv */
package core_platform_csr_pkg;
    typedef enum logic [1:0]
    {
        PW_IDLE = 2'b00,
        PW_READ = 2'b01,
        PW_MERGE = 2'b11
    } pw_state_t;
    typedef logic [31:0] word_t;
    typedef logic [6:0] ecc_t;
endpackage : core_platform_csr_pkg

/* File: common/merge_if.sv */
`timescale 1ns/100ps
interface merge_if;
    logic start;
    core_platform_csr_pkg::word_t oldWord;
    core_platform_csr_pkg::word_t newData;
    logic [3:0] byteEn;
    core_platform_csr_pkg::word_t mergedWord;
    core_platform_csr_pkg::ecc_t ecc;
    modport requester (output start, output oldWord, output newData, output byteEn,
        input mergedWord, input ecc);
    modport merger (input start, input oldWord, input newData, input byteEn,
        output mergedWord, output ecc);
endinterface : merge_if

/* File: rtl/partial_write_merge.sv */
`timescale 1ns/100ps
`include "core_platform_csr_regs.svh"
module partial_write_merge
(
    input wire logic clk,
    input wire logic nrst,
    merge_if.merger mg
);
    localparam logic [31:0] MASKS [6] = '{`ECC_MASK0, `ECC_MASK1, `ECC_MASK2,
        `ECC_MASK3, `ECC_MASK4, `ECC_MASK5};
    core_platform_csr_pkg::word_t merged_reg;
    core_platform_csr_pkg::word_t merged_next;
    core_platform_csr_pkg::ecc_t ecc_reg;
    core_platform_csr_pkg::ecc_t ecc_next;

    function automatic core_platform_csr_pkg::ecc_t eccOf(input logic [31:0] d);
        core_platform_csr_pkg::ecc_t e;
        e = '0;
        for (int i = 0; i < 6; i++)
        begin
            e[i] = ^(d & MASKS[i]);
        end
        e[6] = ^{d, e[5:0]};
        return e;
    endfunction : eccOf

    // Byte merge of new data over stored word, then fresh check bits
    always_comb
    begin
        merged_next = merged_reg;
        ecc_next = ecc_reg;
        if (mg.start)
        begin
            for (int b = 0; b < 4; b++)
            begin
                merged_next[b*8 +: 8] = mg.byteEn[b] ? mg.newData[b*8 +: 8]
                    : mg.oldWord[b*8 +: 8];
            end
            ecc_next = eccOf(merged_next);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            merged_reg <= '0;
            ecc_reg <= '0;
        end
        else
        begin
            merged_reg <= merged_next;
            ecc_reg <= ecc_next;
        end
    end

    assign mg.mergedWord = merged_reg;
    assign mg.ecc = ecc_reg;
endmodule : partial_write_merge

/* File: rtl/core_platform_csr_bank.sv */
`timescale 1ns/100ps
`include "core_platform_csr_regs.svh"
module core_platform_csr_bank #(
    parameter logic [31:0] LOCAL_INSTR_BASE = 32'h0004_0000,
    parameter logic [31:0] LOCAL_INSTR_MASK = 32'hfffe_0000,
    parameter logic [31:0] LOCAL_DATA_BASE = 32'h0008_0000,
    parameter logic [31:0] LOCAL_DATA_MASK = 32'hfffe_0000,
    parameter logic [31:0] INTC_REGS_BASE = 32'hf00c_0000,
    parameter logic [31:0] INTC_REGS_MASK = 32'hffff_8000
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic csrValid,
    input wire logic csrWrite,
    input wire logic [11:0] csrAddr,
    input wire logic [31:0] csrWdata,
    input wire logic csrDebugMode,
    output logic csrAck,
    output logic csrHit,
    output logic csrIllegal,
    output logic [31:0] csrRdata,
    output logic dataFence,
    output logic instrFence,
    input wire logic storeErr,
    input wire logic loadErr,
    input wire logic [31:0] errAddr,
    input wire logic nmiPin,
    output logic nmiReq,
    output logic [31:0] nmiCause,
    input wire logic [31:0] fetchAddr,
    input wire logic [31:0] lsAddr,
    output logic fetchSideEffect,
    output logic fetchCacheable,
    output logic lsSideEffect,
    output logic lsCacheable,
    input wire logic wrValid,
    input wire logic [31:0] wrAddr,
    input wire logic [31:0] wrData,
    input wire logic [3:0] wrByteEn,
    output logic wrReady,
    output logic localRdReq,
    output logic [31:0] localAddr,
    input wire logic localRdValid,
    input wire logic [31:0] localRdata,
    output logic localWrValid,
    output logic [31:0] localWrData,
    output logic [6:0] localWrEcc,
    output logic busWrValid,
    output logic [31:0] busWrAddr,
    output logic [31:0] busWrData,
    output logic [3:0] busWrByteEn
);
    function automatic logic inWin(input logic [31:0] a, input logic [31:0] base,
        input logic [31:0] mask);
        return (a & mask) == (base & mask);
    endfunction : inWin

    function automatic logic [31:0] legalize(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        for (int i = 0; i < 16; i++)
        begin
            if (v[2*i+1])
            begin
                r[2*i] = 1'b0;
            end
        end
        return r;
    endfunction : legalize

    function automatic logic [4:0] bitIdx(input logic [31:0] a, input logic se);
        return {a[`REGION_MSB:`REGION_LSB], se};
    endfunction : bitIdx

    logic [31:0] regionAccess_reg, regionAccess_next;
    logic [31:0] capture_reg, capture_next;
    logic locked_reg, locked_next;
    logic csrAck_next, csrHit_next, csrIllegal_next;
    logic [31:0] csrRdata_next;
    logic dataFence_next, instrFence_next;
    logic nmiReq_next, pinPending_reg, pinPending_next;
    logic [31:0] nmiCause_next;
    logic pinSync1_reg, pinSync2_reg, pinSync3_reg;
    logic fetchSideEffect_next, fetchCacheable_next, lsSideEffect_next, lsCacheable_next;
    logic hit, illegal, doWrite, busNmi, pinEdge, fetchLocal, lsLocal;

    // CSR decode, access check and read mux
    always_comb
    begin
        hit = csrAddr == `CSR_REGION_ACCESS || csrAddr == `CSR_SYNC_TRIGGER
            || csrAddr == `CSR_ERR_UNLOCK || csrAddr == `CSR_ERR_CAPTURE;
        illegal = (csrAddr == `CSR_SYNC_TRIGGER && !csrDebugMode)
            || (csrAddr == `CSR_ERR_CAPTURE && csrWrite);
        doWrite = csrValid && csrWrite && hit && !illegal;
        csrAck_next = csrValid;
        csrHit_next = csrValid && hit;
        csrIllegal_next = csrValid && hit && illegal;
        csrRdata_next = 32'h0000_0000;
        if (csrValid && hit && !illegal && !csrWrite)
        begin
            if (csrAddr == `CSR_REGION_ACCESS)
            begin
                csrRdata_next = regionAccess_reg;
            end
            else if (csrAddr == `CSR_ERR_CAPTURE)
            begin
                csrRdata_next = capture_reg;
            end
        end
        regionAccess_next = regionAccess_reg;
        if (doWrite && csrAddr == `CSR_REGION_ACCESS)
        begin
            regionAccess_next = legalize(csrWdata);
        end
        dataFence_next = doWrite && csrAddr == `CSR_SYNC_TRIGGER
            && csrWdata[`SYNC_DATA_FENCE_BIT];
        instrFence_next = doWrite && csrAddr == `CSR_SYNC_TRIGGER
            && csrWdata[`SYNC_INSTR_FENCE_BIT];
    end

    // Error capture, lock and NMI request
    always_comb
    begin
        busNmi = (storeErr || loadErr) && !locked_reg;
        pinEdge = pinSync2_reg && !pinSync3_reg;
        capture_next = capture_reg;
        locked_next = locked_reg;
        if (busNmi)
        begin
            capture_next = errAddr;
            locked_next = 1'b1;
        end
        else if (doWrite && csrAddr == `CSR_ERR_UNLOCK)
        begin
            locked_next = 1'b0;
        end
        nmiReq_next = busNmi || pinPending_reg || pinEdge;
        pinPending_next = (pinPending_reg || pinEdge) && busNmi;
        nmiCause_next = `CAUSE_PIN;
        if (busNmi)
        begin
            nmiCause_next = storeErr ? `CAUSE_STORE_ERR : `CAUSE_LOAD_ERR;
        end
    end

    // Region attribute lookup
    always_comb
    begin
        fetchLocal = inWin(fetchAddr, LOCAL_INSTR_BASE, LOCAL_INSTR_MASK);
        lsLocal = inWin(lsAddr, LOCAL_INSTR_BASE, LOCAL_INSTR_MASK)
            || inWin(lsAddr, LOCAL_DATA_BASE, LOCAL_DATA_MASK)
            || inWin(lsAddr, INTC_REGS_BASE, INTC_REGS_MASK);
        fetchSideEffect_next = 1'b0;
        fetchCacheable_next = !fetchLocal && regionAccess_reg[bitIdx(fetchAddr, 1'b0)];
        lsSideEffect_next = !lsLocal && regionAccess_reg[bitIdx(lsAddr, 1'b1)];
        lsCacheable_next = regionAccess_reg[bitIdx(lsAddr, 1'b0)];
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            regionAccess_reg <= `REGION_ACCESS_RESET;
            capture_reg <= `CAPTURE_RESET;
            locked_reg <= 1'b0;
            csrAck <= 1'b0;
            csrHit <= 1'b0;
            csrIllegal <= 1'b0;
            csrRdata <= '0;
            dataFence <= 1'b0;
            instrFence <= 1'b0;
            nmiReq <= 1'b0;
            nmiCause <= '0;
            pinPending_reg <= 1'b0;
            pinSync1_reg <= 1'b0;
            pinSync2_reg <= 1'b0;
            pinSync3_reg <= 1'b0;
            fetchSideEffect <= 1'b0;
            fetchCacheable <= 1'b0;
            lsSideEffect <= 1'b0;
            lsCacheable <= 1'b0;
        end
        else
        begin
            regionAccess_reg <= regionAccess_next;
            capture_reg <= capture_next;
            locked_reg <= locked_next;
            csrAck <= csrAck_next;
            csrHit <= csrHit_next;
            csrIllegal <= csrIllegal_next;
            csrRdata <= csrRdata_next;
            dataFence <= dataFence_next;
            instrFence <= instrFence_next;
            nmiReq <= nmiReq_next;
            nmiCause <= nmiCause_next;
            pinPending_reg <= pinPending_next;
            pinSync1_reg <= nmiPin;
            pinSync2_reg <= pinSync1_reg;
            pinSync3_reg <= pinSync2_reg;
            fetchSideEffect <= fetchSideEffect_next;
            fetchCacheable <= fetchCacheable_next;
            lsSideEffect <= lsSideEffect_next;
            lsCacheable <= lsCacheable_next;
        end
    end

    // Partial write path
    core_platform_csr_pkg::pw_state_t state_reg, state_next;
    logic [31:0] pwData_reg, pwData_next;
    logic [3:0] pwByteEn_reg, pwByteEn_next;
    logic wrReady_next, localRdReq_next, localWrValid_next;
    logic [31:0] localAddr_next;
    logic busWrValid_next;
    logic [31:0] busWrAddr_next, busWrData_next;
    logic [3:0] busWrByteEn_next;
    logic wrLocal;
    merge_if mg ();

    partial_write_merge u_merge (
        .clk(clk),
        .nrst(nrst),
        .mg(mg.merger)
    );

    assign mg.start = state_reg == core_platform_csr_pkg::PW_READ && localRdValid;
    assign mg.oldWord = localRdata;
    assign mg.newData = pwData_reg;
    assign mg.byteEn = pwByteEn_reg;
    assign localWrData = mg.mergedWord;
    assign localWrEcc = mg.ecc;

    always_comb
    begin
        wrLocal = inWin(wrAddr, LOCAL_INSTR_BASE, LOCAL_INSTR_MASK)
            || inWin(wrAddr, LOCAL_DATA_BASE, LOCAL_DATA_MASK);
        state_next = state_reg;
        pwData_next = pwData_reg;
        pwByteEn_next = pwByteEn_reg;
        localAddr_next = localAddr;
        localRdReq_next = 1'b0;
        localWrValid_next = 1'b0;
        busWrValid_next = 1'b0;
        busWrAddr_next = busWrAddr;
        busWrData_next = busWrData;
        busWrByteEn_next = busWrByteEn;
        case (state_reg)
            core_platform_csr_pkg::PW_IDLE:
            begin
                if (wrValid && wrLocal)
                begin
                    pwData_next = wrData;
                    pwByteEn_next = wrByteEn;
                    localAddr_next = wrAddr;
                    localRdReq_next = 1'b1;
                    state_next = core_platform_csr_pkg::PW_READ;
                end
                else if (wrValid)
                begin
                    busWrValid_next = 1'b1;
                    busWrAddr_next = wrAddr;
                    busWrData_next = wrData;
                    busWrByteEn_next = wrByteEn;
                end
            end
            core_platform_csr_pkg::PW_READ:
            begin
                if (localRdValid)
                begin
                    state_next = core_platform_csr_pkg::PW_MERGE;
                end
            end
            core_platform_csr_pkg::PW_MERGE:
            begin
                localWrValid_next = 1'b1;
                state_next = core_platform_csr_pkg::PW_IDLE;
            end
            default:
            begin
                state_next = core_platform_csr_pkg::PW_IDLE;
            end
        endcase
        wrReady_next = state_next == core_platform_csr_pkg::PW_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_reg <= core_platform_csr_pkg::PW_IDLE;
            pwData_reg <= '0;
            pwByteEn_reg <= '0;
            wrReady <= 1'b0;
            localRdReq <= 1'b0;
            localAddr <= '0;
            localWrValid <= 1'b0;
            busWrValid <= 1'b0;
            busWrAddr <= '0;
            busWrData <= '0;
            busWrByteEn <= '0;
        end
        else
        begin
            state_reg <= state_next;
            pwData_reg <= pwData_next;
            pwByteEn_reg <= pwByteEn_next;
            wrReady <= wrReady_next;
            localRdReq <= localRdReq_next;
            localAddr <= localAddr_next;
            localWrValid <= localWrValid_next;
            busWrValid <= busWrValid_next;
            busWrAddr <= busWrAddr_next;
            busWrData <= busWrData_next;
            busWrByteEn <= busWrByteEn_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_legal_pairs;
        legalize(regionAccess_reg) == regionAccess_reg;
    endproperty
    a_legal_pairs: assert property (p_legal_pairs) else $error("illegal pair held");
    property p_write_map;
        csrValid && csrWrite && csrAddr == `CSR_REGION_ACCESS && csrWdata[1:0] == 2'b11
            |=> regionAccess_reg[1:0] == 2'b10;
    endproperty
    a_write_map: assert property (p_write_map) else $error("pair not mapped");
    property p_sync_debug;
        csrValid && csrAddr == `CSR_SYNC_TRIGGER && !csrDebugMode
            |=> csrIllegal && !dataFence && !instrFence;
    endproperty
    a_sync_debug: assert property (p_sync_debug) else $error("sync access not trapped");
    property p_fence;
        csrValid && csrWrite && csrDebugMode && csrAddr == `CSR_SYNC_TRIGGER
            |=> dataFence == $past(csrWdata[1]) && instrFence == $past(csrWdata[0]);
    endproperty
    a_fence: assert property (p_fence) else $error("fence trigger wrong");
    property p_zero_reads;
        csrValid && !csrWrite && (csrAddr == `CSR_SYNC_TRIGGER || csrAddr == `CSR_ERR_UNLOCK)
            |=> csrRdata == 32'h0000_0000;
    endproperty
    a_zero_reads: assert property (p_zero_reads) else $error("zero register read nonzero");
    property p_capture;
        (storeErr || loadErr) && !locked_reg
            |=> locked_reg && capture_reg == $past(errAddr) && nmiReq;
    endproperty
    a_capture: assert property (p_capture) else $error("first error not captured");
    property p_gated;
        (storeErr || loadErr) && locked_reg && !pinPending_reg && !pinEdge
            |=> !nmiReq && $stable(capture_reg);
    endproperty
    a_gated: assert property (p_gated) else $error("locked error not gated");
    property p_unlock;
        csrValid && csrWrite && csrAddr == `CSR_ERR_UNLOCK && !storeErr && !loadErr
            |=> !locked_reg;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock failed");
    property p_cause;
        (storeErr || loadErr) && !locked_reg
            |=> nmiCause == ($past(storeErr) ? `CAUSE_STORE_ERR : `CAUSE_LOAD_ERR);
    endproperty
    a_cause: assert property (p_cause) else $error("wrong NMI cause");
    property p_fetch_se;
        !fetchSideEffect;
    endproperty
    a_fetch_se: assert property (p_fetch_se) else $error("fetch side effect set");
    property p_rmw;
        state_reg == core_platform_csr_pkg::PW_IDLE && wrValid && wrLocal
            |=> localRdReq ##[1:20] localWrValid;
    endproperty
    a_rmw: assert property (p_rmw) else $error("no local write back");
    property p_soc_be;
        state_reg == core_platform_csr_pkg::PW_IDLE && wrValid && !wrLocal
            |=> busWrValid && busWrByteEn == $past(wrByteEn);
    endproperty
    a_soc_be: assert property (p_soc_be) else $error("byte enables lost");

    c_lock_unlock: cover property (locked_reg ##[1:10] !locked_reg);
    c_pin_nmi: cover property (nmiReq && nmiCause == `CAUSE_PIN);
    c_rmw: cover property (localWrValid);
    c_fence: cover property (dataFence && instrFence);
endmodule : core_platform_csr_bank

/* File: tb/test_core_platform_csr_bank.sv */
`timescale 1ns/100ps
`include "core_platform_csr_regs.svh"
module test_core_platform_csr_bank;
    logic clk, nrst, csrValid, csrWrite, csrDebugMode, storeErr, loadErr, nmiPin;
    logic [11:0] csrAddr;
    logic [31:0] csrWdata, errAddr, fetchAddr, lsAddr, wrAddr, wrData, localRdata;
    logic wrValid, localRdValid;
    logic [3:0] wrByteEn;
    logic csrAck, csrHit, csrIllegal, dataFence, instrFence, nmiReq;
    logic [31:0] csrRdata, nmiCause, localAddr, localWrData, busWrAddr, busWrData;
    logic fetchSideEffect, fetchCacheable, lsSideEffect, lsCacheable, wrReady;
    logic localRdReq, localWrValid, busWrValid;
    logic [6:0] localWrEcc;
    logic [3:0] busWrByteEn;
    logic [31:0] rd, causeS, expReg;
    logic hit, ill, df, inf, nmiS, ack;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    core_platform_csr_bank dut_u (.clk(clk), .nrst(nrst), .csrValid(csrValid),
        .csrWrite(csrWrite), .csrAddr(csrAddr), .csrWdata(csrWdata),
        .csrDebugMode(csrDebugMode), .csrAck(csrAck), .csrHit(csrHit),
        .csrIllegal(csrIllegal), .csrRdata(csrRdata), .dataFence(dataFence),
        .instrFence(instrFence), .storeErr(storeErr), .loadErr(loadErr), .errAddr(errAddr),
        .nmiPin(nmiPin), .nmiReq(nmiReq), .nmiCause(nmiCause), .fetchAddr(fetchAddr),
        .lsAddr(lsAddr), .fetchSideEffect(fetchSideEffect), .fetchCacheable(fetchCacheable),
        .lsSideEffect(lsSideEffect), .lsCacheable(lsCacheable), .wrValid(wrValid),
        .wrAddr(wrAddr), .wrData(wrData), .wrByteEn(wrByteEn), .wrReady(wrReady),
        .localRdReq(localRdReq), .localAddr(localAddr), .localRdValid(localRdValid),
        .localRdata(localRdata), .localWrValid(localWrValid), .localWrData(localWrData),
        .localWrEcc(localWrEcc), .busWrValid(busWrValid), .busWrAddr(busWrAddr),
        .busWrData(busWrData), .busWrByteEn(busWrByteEn));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    task check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Register access: drive, sample the answer one cycle later, idle one cycle
    task csr(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic dbg);
        csrValid = 1'b1;
        csrWrite = wr;
        csrAddr = a;
        csrWdata = d;
        csrDebugMode = dbg;
        @(negedge clk);
        rd = csrRdata;
        ack = csrAck;
        hit = csrHit;
        ill = csrIllegal;
        df = dataFence;
        inf = instrFence;
        csrValid = 1'b0;
        @(negedge clk);
    endtask : csr

    task busErr(input logic st, input logic ld, input logic [31:0] a);
        storeErr = st;
        loadErr = ld;
        errAddr = a;
        @(negedge clk);
        nmiS = nmiReq;
        causeS = nmiCause;
        storeErr = 1'b0;
        loadErr = 1'b0;
        @(negedge clk);
    endtask : busErr

    // Illegal attribute pair becomes side-effect only
    function automatic logic [31:0] legal(input logic [31:0] v);
        for (int i = 0; i < 16; i++)
            if (v[2*i+1])
                v[2*i] = 1'b0;
        return v;
    endfunction : legal

    function automatic logic [5:0] ecc6(input logic [31:0] d);
        return {^(d & `ECC_MASK5), ^(d & `ECC_MASK4), ^(d & `ECC_MASK3),
            ^(d & `ECC_MASK2), ^(d & `ECC_MASK1), ^(d & `ECC_MASK0)};
    endfunction : ecc6

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        {nrst, csrValid, csrWrite, csrDebugMode, storeErr, loadErr, nmiPin} = '0;
        {csrAddr, csrWdata, errAddr, fetchAddr, lsAddr, wrAddr, wrData, localRdata} = '0;
        {wrValid, localRdValid, wrByteEn} = '0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        check("wrReady", wrReady, 1'b1);
        csr(1'b0, `CSR_REGION_ACCESS, 32'h0, 1'b0);
        check("region reset", rd, 32'h0000_0000);
        csr(1'b0, `CSR_ERR_CAPTURE, 32'h0, 1'b0);
        check("capture reset", rd, 32'h0000_0000);
        csr(1'b0, 12'h7c8, 32'h0, 1'b0);
        check("unmapped hit", {hit, rd}, 33'h0);
        expReg = legal(32'hb4e1_d27b);
        csr(1'b1, `CSR_REGION_ACCESS, 32'hb4e1_d27b, 1'b0);
        csr(1'b0, `CSR_REGION_ACCESS, 32'h0, 1'b0);
        check("region legal", rd, expReg);
        check("csr ack", ack, 1'b1);
        csr(1'b1, `CSR_SYNC_TRIGGER, 32'h3, 1'b1);
        check("fence after update", {ill, df, inf}, 3'b011);
        for (n = 0; n < 16; n++)
        begin
            lsAddr = {n[3:0], 28'h000_0100};
            fetchAddr = lsAddr;
            @(negedge clk);
            check("ls side", lsSideEffect, expReg[2*n+1]);
            check("ls cache", lsCacheable, expReg[2*n]);
            check("fetch side", fetchSideEffect, 1'b0);
            check("fetch cache", fetchCacheable, expReg[2*n]);
        end
        lsAddr = 32'h0008_0040;
        @(negedge clk);
        check("local side", lsSideEffect, 1'b0);
        lsAddr = 32'hf00c_0010;
        @(negedge clk);
        check("intc side", lsSideEffect, 1'b0);
        csr(1'b1, `CSR_REGION_ACCESS, 32'h0000_0001, 1'b0);
        fetchAddr = 32'h0004_0100;
        lsAddr = 32'h0004_0100;
        @(negedge clk);
        check("local fetch cache", fetchCacheable, 1'b0);
        check("local ls cache", lsCacheable, 1'b1);
        csr(1'b1, `CSR_SYNC_TRIGGER, 32'h3, 1'b0);
        check("trigger outside debug", {ill, df, inf}, 3'b100);
        csr(1'b1, `CSR_SYNC_TRIGGER, 32'h2, 1'b1);
        check("data fence", {ill, df, inf}, 3'b010);
        csr(1'b1, `CSR_SYNC_TRIGGER, 32'h1, 1'b1);
        check("instr fence", {ill, df, inf}, 3'b001);
        csr(1'b0, `CSR_SYNC_TRIGGER, 32'h0, 1'b1);
        check("trigger read", {ill, rd}, 33'h0);
        busErr(1'b1, 1'b0, 32'h2000_1234);
        check("store nmi", {nmiS, causeS}, {1'b1, `CAUSE_STORE_ERR});
        busErr(1'b0, 1'b1, 32'h3000_5678);
        check("locked nmi", nmiS, 1'b0);
        csr(1'b0, `CSR_ERR_CAPTURE, 32'h0, 1'b0);
        check("capture", rd, 32'h2000_1234);
        csr(1'b1, `CSR_ERR_CAPTURE, 32'hffff_ffff, 1'b0);
        check("capture write", ill, 1'b1);
        nmiPin = 1'b1;
        for (n = 0; n < 8 && nmiReq !== 1'b1; n++)
            @(negedge clk);
        check("pin nmi", {nmiReq, nmiCause}, {1'b1, `CAUSE_PIN});
        nmiPin = 1'b0;
        csr(1'b1, `CSR_ERR_UNLOCK, 32'h5a5a_0000, 1'b0);
        csr(1'b0, `CSR_ERR_UNLOCK, 32'h0, 1'b0);
        check("unlock read", {hit, rd}, 33'h1_0000_0000);
        csr(1'b0, `CSR_ERR_CAPTURE, 32'h0, 1'b0);
        check("capture kept", rd, 32'h2000_1234);
        busErr(1'b0, 1'b1, 32'h4000_0abc);
        check("load nmi", {nmiS, causeS}, {1'b1, `CAUSE_LOAD_ERR});
        csr(1'b0, `CSR_ERR_CAPTURE, 32'h0, 1'b0);
        check("capture new", rd, 32'h4000_0abc);
        wrValid = 1'b1;
        wrAddr = 32'h0008_0010;
        wrData = 32'ha1b2_c3d4;
        wrByteEn = 4'b0101;
        @(negedge clk);
        wrValid = 1'b0;
        check("rmw read", {localRdReq, wrReady, localAddr}, {2'b10, 32'h0008_0010});
        localRdValid = 1'b1;
        localRdata = 32'h1122_3344;
        @(negedge clk);
        localRdValid = 1'b0;
        for (n = 0; n < 8 && localWrValid !== 1'b1; n++)
            @(negedge clk);
        check("rmw data", localWrData, 32'h11b2_33d4);
        check("rmw ecc", localWrEcc[5:0], ecc6(32'h11b2_33d4));
        check("rmw ecc top", localWrEcc[6], ^{32'h11b2_33d4, ecc6(32'h11b2_33d4)});
        check("rmw ready", wrReady, 1'b1);
        @(negedge clk);
        wrValid = 1'b1;
        wrAddr = 32'h2000_0004;
        wrData = 32'h99aa_bbcc;
        wrByteEn = 4'b1000;
        @(negedge clk);
        wrValid = 1'b0;
        check("soc valid", {busWrValid, localRdReq, busWrByteEn}, 6'b10_1000);
        check("soc addr", busWrAddr, 32'h2000_0004);
        check("soc data", busWrData, 32'h99aa_bbcc);
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        csr(1'b0, `CSR_ERR_CAPTURE, 32'h0, 1'b0);
        check("capture after reset", rd, 32'h0000_0000);
        csr(1'b0, `CSR_REGION_ACCESS, 32'h0, 1'b0);
        check("region after reset", rd, 32'h0000_0000);
        busErr(1'b1, 1'b0, 32'h5000_0008);
        check("nmi after reset", {nmiS, causeS}, {1'b1, `CAUSE_STORE_ERR});
        @(negedge clk);
        give_verdict();
    end
endmodule : test_core_platform_csr_bank
